// ---- rtl/dpcc_top.sv ----
// Purpose: Register file and spread-spectrum modulator for the two clock synthesizers.
// Assumes: The host writes settings only while streaming is stopped.
// Notes: The analog loops sit outside; this block drives their control words.
`timescale 1ns/1ps
// Function
// - Two synthesizers share the external reference.
// - Spread mode gives triangular frequency modulation while fractional mode and the output enable are on.
// - Multiplication is 2*div1+7+div2+frac/512.
// - System synthesizer: predivider, multiplier, postdivider bytes.
// - Output synthesizer: predivider, two dividers, postdivider.
// - Control A: link halving and enable.
// - Control B: step, frequency, spread, fractional.
// - Fractional limits assembled from four bytes.
// - Loop config: precision, counter, fastlock, pump.
module dpcc_top (
  input wire logic mclk, // System clock, 25 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ext_ref_clock_in, // Reference clock pin, passed to both synthesizers.
  input wire logic [15:0] reg_addr, // Register address.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd, // Read strobe, one cycle.
  output logic [7:0] reg_rdata, // Read data, registered.
  output logic sys_ref_clk, // Reference to the system synthesizer.
  output logic out_ref_clk, // Reference to the output synthesizer.
  output logic [7:0] sys_predivider, // System synthesizer predivider.
  output logic [7:0] sys_multiplier, // System synthesizer multiplier.
  output logic [4:0] sys_postdivider, // System postdivider, 1 to 16.
  output logic [1:0] sys_lock_precision, // System lock detector precision.
  output logic [1:0] sys_lock_count, // System lock counter setting.
  output logic sys_fastlock_en, // System fast locking enabled.
  output logic [2:0] sys_charge_pump_current, // System charge pump current.
  output logic [7:0] reference_predivider, // Output synthesizer predivider.
  output logic [8:0] out_first_divider, // Output first divider, 1 to 256.
  output logic [7:0] out_second_divider, // Output second divider.
  output logic [4:0] out_postdivider, // Output postdivider, 1 to 16.
  output logic output_clock_synth_en, // Output synthesizer enable.
  output logic link_half_rate, // Halve the serial link frequency.
  output logic frac_mode_en, // Fractional mode enable.
  output logic spread_modulation_mode, // Spread-spectrum mode active.
  output logic [1:0] out_lock_precision, // Output lock detector precision.
  output logic [1:0] out_lock_count, // Output lock counter setting.
  output logic out_fastlock_en, // Output fast locking enabled.
  output logic [2:0] charge_pump_current, // Output charge pump current.
  output logic [9:0] frac_applied, // Fractional value applied now.
  output logic [21:0] mult_integer // Integer part of the effective multiplication.
);

  // Register storage.
  // Each byte register keeps its next value beside it.
  logic [7:0] sys_pre_reg, sys_pre_next; // System predivider.
  logic [7:0] sys_mult_reg, sys_mult_next; // System multiplier.
  logic [7:0] sys_post_reg, sys_post_next; // System postdivider.
  logic [7:0] sys_cfg_reg, sys_cfg_next; // System loop configuration.
  logic [7:0] out_pre_reg, out_pre_next; // Output predivider.
  logic [7:0] out_div1_reg, out_div1_next; // Output first divider.
  logic [7:0] out_div2_reg, out_div2_next; // Output second divider.
  logic [7:0] out_post_reg, out_post_next; // Output postdivider.
  logic [7:0] ctla_reg, ctla_next; // Output control A.
  logic [7:0] ctlb_reg, ctlb_next; // Output control B.
  logic [7:0] max_h_reg, max_h_next; // Maximum fraction high.
  logic [7:0] max_l_reg, max_l_next; // Maximum fraction low.
  logic [7:0] min_h_reg, min_h_next; // Minimum fraction high.
  logic [7:0] min_l_reg, min_l_next; // Minimum fraction low.
  logic [7:0] out_cfg_reg, out_cfg_next; // Output loop configuration.
  logic [7:0] rdata_reg, rdata_next; // Read data.
  // Modulator state.
  dpcc_pkg::dpcc_sweep_t sweep_reg, sweep_next; // Sweep direction.
  logic [9:0] frac_reg, frac_next; // Applied fraction.
  logic [11:0] tick_reg, tick_next; // Step interval counter.
  // Derived values.
  // These follow the stored bytes without delay.
  logic [9:0] frac_max; // Modulation maximum.
  logic [9:0] frac_min; // Modulation minimum.
  logic [11:0] tick_period; // Cycles between steps.
  logic [9:0] step_size; // Fraction step per tick.

  // Fraction limits are built from the two byte pairs.
  // A limit written in two halves is mixed for a moment.
  assign frac_max = {max_h_reg[1:0], max_l_reg};
  assign frac_min = {min_h_reg[1:0], min_l_reg};
  // Step interval scales by the counter frequency field.
  assign tick_period = 12'(dpcc_pkg::MOD_BASE_CYCLES <<
    ctlb_reg[dpcc_pkg::CTLB_FREQ_HI:dpcc_pkg::CTLB_FREQ_LO]);
  // Step size is 1, 2, 4 or 8 codes.
  // Larger steps shorten the sweep; the limits clamp the last step.
  assign step_size = 10'(10'h001 <<
    ctlb_reg[dpcc_pkg::CTLB_STEP_HI:dpcc_pkg::CTLB_STEP_LO]);

  // Register write decode and read mux.
  // Both strobes may stand in one cycle; each is decoded alone.
  always_comb begin
    sys_pre_next = sys_pre_reg;
    sys_mult_next = sys_mult_reg;
    sys_post_next = sys_post_reg;
    sys_cfg_next = sys_cfg_reg;
    out_pre_next = out_pre_reg;
    out_div1_next = out_div1_reg;
    out_div2_next = out_div2_reg;
    out_post_next = out_post_reg;
    ctla_next = ctla_reg;
    ctlb_next = ctlb_reg;
    max_h_next = max_h_reg;
    max_l_next = max_l_reg;
    min_h_next = min_h_reg;
    min_l_next = min_l_reg;
    out_cfg_next = out_cfg_reg;
    rdata_next = rdata_reg;
    // Unused control and high limit bits are stored as zero.
    // Writes land directly; the host keeps them to standby.
    if (reg_wr) begin
      case (reg_addr)
        dpcc_pkg::ADDR_SYS_PRE: sys_pre_next = reg_wdata;
        dpcc_pkg::ADDR_SYS_MULT: sys_mult_next = reg_wdata;
        dpcc_pkg::ADDR_SYS_POST: sys_post_next = reg_wdata;
        dpcc_pkg::ADDR_SYS_CFG: sys_cfg_next = reg_wdata;
        dpcc_pkg::ADDR_OUT_PRE: out_pre_next = reg_wdata;
        dpcc_pkg::ADDR_OUT_DIV1: out_div1_next = reg_wdata;
        dpcc_pkg::ADDR_OUT_DIV2: out_div2_next = reg_wdata;
        dpcc_pkg::ADDR_OUT_POST: out_post_next = reg_wdata;
        dpcc_pkg::ADDR_OUT_CTLA: ctla_next = {6'h00, reg_wdata[1:0]};
        dpcc_pkg::ADDR_OUT_CTLB: ctlb_next = {1'b0, reg_wdata[6:0]};
        dpcc_pkg::ADDR_MAX_H: max_h_next = {6'h00, reg_wdata[1:0]};
        dpcc_pkg::ADDR_MAX_L: max_l_next = reg_wdata;
        dpcc_pkg::ADDR_MIN_H: min_h_next = {6'h00, reg_wdata[1:0]};
        dpcc_pkg::ADDR_MIN_L: min_l_next = reg_wdata;
        dpcc_pkg::ADDR_OUT_CFG: out_cfg_next = reg_wdata;
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
    // A read in the cycle of a write returns the old byte.
    // Reads return the stored byte; unmapped addresses read zero.
    if (reg_rd) begin
      case (reg_addr)
        dpcc_pkg::ADDR_SYS_PRE: rdata_next = sys_pre_reg;
        dpcc_pkg::ADDR_SYS_MULT: rdata_next = sys_mult_reg;
        dpcc_pkg::ADDR_SYS_POST: rdata_next = sys_post_reg;
        dpcc_pkg::ADDR_SYS_CFG: rdata_next = sys_cfg_reg;
        dpcc_pkg::ADDR_OUT_PRE: rdata_next = out_pre_reg;
        dpcc_pkg::ADDR_OUT_DIV1: rdata_next = out_div1_reg;
        dpcc_pkg::ADDR_OUT_DIV2: rdata_next = out_div2_reg;
        dpcc_pkg::ADDR_OUT_POST: rdata_next = out_post_reg;
        dpcc_pkg::ADDR_OUT_CTLA: rdata_next = ctla_reg;
        dpcc_pkg::ADDR_OUT_CTLB: rdata_next = ctlb_reg;
        dpcc_pkg::ADDR_MAX_H: rdata_next = max_h_reg;
        dpcc_pkg::ADDR_MAX_L: rdata_next = max_l_reg;
        dpcc_pkg::ADDR_MIN_H: rdata_next = min_h_reg;
        dpcc_pkg::ADDR_MIN_L: rdata_next = min_l_reg;
        dpcc_pkg::ADDR_OUT_CFG: rdata_next = out_cfg_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register storage flops.
  // The read data register holds until the next read strobe.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_pre_reg <= dpcc_pkg::RST_SYS_PRE;
      sys_mult_reg <= dpcc_pkg::RST_SYS_MULT;
      sys_post_reg <= dpcc_pkg::RST_SYS_POST;
      sys_cfg_reg <= dpcc_pkg::RST_SYS_CFG;
      out_pre_reg <= dpcc_pkg::RST_OUT_PRE;
      out_div1_reg <= dpcc_pkg::RST_OUT_DIV1;
      out_div2_reg <= dpcc_pkg::RST_OUT_DIV2;
      out_post_reg <= dpcc_pkg::RST_OUT_POST;
      ctla_reg <= dpcc_pkg::RST_OUT_CTLA;
      ctlb_reg <= dpcc_pkg::RST_OUT_CTLB;
      max_h_reg <= dpcc_pkg::RST_FRAC;
      max_l_reg <= dpcc_pkg::RST_FRAC;
      min_h_reg <= dpcc_pkg::RST_FRAC;
      min_l_reg <= dpcc_pkg::RST_FRAC;
      out_cfg_reg <= dpcc_pkg::RST_OUT_CFG;
      rdata_reg <= 8'h00;
    end else begin
      sys_pre_reg <= sys_pre_next;
      sys_mult_reg <= sys_mult_next;
      sys_post_reg <= sys_post_next;
      sys_cfg_reg <= sys_cfg_next;
      out_pre_reg <= out_pre_next;
      out_div1_reg <= out_div1_next;
      out_div2_reg <= out_div2_next;
      out_post_reg <= out_post_next;
      ctla_reg <= ctla_next;
      ctlb_reg <= ctlb_next;
      max_h_reg <= max_h_next;
      max_l_reg <= max_l_next;
      min_h_reg <= min_h_next;
      min_l_reg <= min_l_next;
      out_cfg_reg <= out_cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // Modulator: triangular sweep of the applied fraction between the limits.
  // The sweep restarts from the minimum whenever spread mode and the output enable both come on.
  always_comb begin
    sweep_next = sweep_reg;
    frac_next = frac_reg;
    tick_next = tick_reg;
    if (!(ctlb_reg[dpcc_pkg::CTLB_SPREAD] && ctla_reg[dpcc_pkg::CTLA_ENABLE])) begin
      // Without spread the fraction rests at the maximum limit.
      sweep_next = dpcc_pkg::DPCC_IDLE;
      frac_next = frac_max;
      tick_next = 12'h000;
    end else begin
      case (sweep_reg)
        dpcc_pkg::DPCC_IDLE: begin
          // Start each sweep from the minimum.
          // The first step then comes a full interval later.
          frac_next = frac_min;
          tick_next = 12'h000;
          sweep_next = dpcc_pkg::DPCC_UP;
        end
        dpcc_pkg::DPCC_UP: begin
          if (tick_reg + 12'h001 >= tick_period) begin
            tick_next = 12'h000;
            // Clamp to the maximum, then turn round.
            // Limits closer than one step still turn cleanly.
            if ({1'b0, frac_reg} + {1'b0, step_size} >= {1'b0, frac_max}) begin
              frac_next = frac_max;
              sweep_next = dpcc_pkg::DPCC_DOWN;
            end else begin
              frac_next = 10'(frac_reg + step_size);
            end
          end else begin
            tick_next = 12'(tick_reg + 12'h001);
          end
        end
        dpcc_pkg::DPCC_DOWN: begin
          if (tick_reg + 12'h001 >= tick_period) begin
            tick_next = 12'h000;
            // Clamp to the minimum, then turn round.
            // The fraction never undershoots, so it cannot wrap.
            if ({1'b0, frac_reg} <= {1'b0, frac_min} + {1'b0, step_size}) begin
              frac_next = frac_min;
              sweep_next = dpcc_pkg::DPCC_UP;
            end else begin
              frac_next = 10'(frac_reg - step_size);
            end
          end else begin
            tick_next = 12'(tick_reg + 12'h001);
          end
        end
        default: begin
          // An illegal state falls back to idle.
          sweep_next = dpcc_pkg::DPCC_IDLE;
        end
      endcase
    end
  end

  // Modulator flops.
  // The sweep waits in its idle state after reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sweep_reg <= dpcc_pkg::DPCC_IDLE;
      frac_reg <= 10'h000;
      tick_reg <= 12'h000;
    end else begin
      sweep_reg <= sweep_next;
      frac_reg <= frac_next;
      tick_reg <= tick_next;
    end
  end

  // Both synthesizers take the same reference pin.
  // The pin is a clock, so it passes on unsampled.
  assign sys_ref_clk = ext_ref_clock_in;
  assign out_ref_clk = ext_ref_clock_in;
  assign reg_rdata = rdata_reg;
  // System synthesizer controls; post code n stands for n+1, so 15 stands for 16.
  assign sys_predivider = sys_pre_reg;
  assign sys_multiplier = sys_mult_reg;
  assign sys_postdivider = {1'b0, sys_post_reg[3:0]} + 5'h01;
  assign sys_lock_precision = sys_cfg_reg[dpcc_pkg::CFG_PREC_HI:dpcc_pkg::CFG_PREC_LO];
  assign sys_lock_count = sys_cfg_reg[dpcc_pkg::CFG_CNT_HI:dpcc_pkg::CFG_CNT_LO];
  assign sys_fastlock_en = ~sys_cfg_reg[dpcc_pkg::CFG_FAST_DIS];
  assign sys_charge_pump_current = sys_cfg_reg[dpcc_pkg::CFG_CP_HI:dpcc_pkg::CFG_CP_LO];
  // Output synthesizer controls; first divider 0 stands for 256.
  // Postdividers use only four bits, so every code is legal.
  assign reference_predivider = out_pre_reg;
  assign out_first_divider = (out_div1_reg == 8'h00) ? 9'h100 : {1'b0, out_div1_reg};
  assign out_second_divider = out_div2_reg;
  assign out_postdivider = {1'b0, out_post_reg[3:0]} + 5'h01;
  assign output_clock_synth_en = ctla_reg[dpcc_pkg::CTLA_ENABLE];
  assign link_half_rate = ctla_reg[dpcc_pkg::CTLA_LINK_HALF];
  assign frac_mode_en = ctlb_reg[dpcc_pkg::CTLB_FRAC];
  assign spread_modulation_mode = ctlb_reg[dpcc_pkg::CTLB_SPREAD];
  assign out_lock_precision = out_cfg_reg[dpcc_pkg::CFG_PREC_HI:dpcc_pkg::CFG_PREC_LO];
  assign out_lock_count = out_cfg_reg[dpcc_pkg::CFG_CNT_HI:dpcc_pkg::CFG_CNT_LO];
  assign out_fastlock_en = ~out_cfg_reg[dpcc_pkg::CFG_FAST_DIS];
  assign charge_pump_current = out_cfg_reg[dpcc_pkg::CFG_CP_HI:dpcc_pkg::CFG_CP_LO];
  // Fraction applied only in fractional mode; its scale is 1/512.
  // The sweep keeps running when fractional mode is off.
  assign frac_applied = frac_mode_en ? frac_reg : 10'h000;
  // Integer part: 2*first + 7 + second, first from the raw byte.
  // A zero first divider code adds nothing to this sum.
  assign mult_integer = 22'({13'h0000, out_div1_reg, 1'b0}) + dpcc_pkg::MULT_OFFSET
    + 22'({14'h0000, out_div2_reg});
endmodule : dpcc_top

// ---- rtl/dpcc_pkg.sv ----
// Purpose: Shared constants for the dual clock synthesizer configuration block.
// Assumes: Byte-wide registers on a 16-bit register address bus.
// Notes: Offsets, field positions and reset values are named once here.
package dpcc_pkg;
  // Register offsets.
  localparam logic [15:0] ADDR_SYS_PRE = 16'h3000;
  localparam logic [15:0] ADDR_SYS_MULT = 16'h3001;
  localparam logic [15:0] ADDR_SYS_POST = 16'h3002;
  localparam logic [15:0] ADDR_SYS_CFG = 16'h3003;
  localparam logic [15:0] ADDR_OUT_PRE = 16'h3004;
  localparam logic [15:0] ADDR_OUT_DIV1 = 16'h3005;
  localparam logic [15:0] ADDR_OUT_DIV2 = 16'h3006;
  localparam logic [15:0] ADDR_OUT_POST = 16'h3007;
  localparam logic [15:0] ADDR_OUT_CTLA = 16'h3008;
  localparam logic [15:0] ADDR_OUT_CTLB = 16'h3009;
  localparam logic [15:0] ADDR_MAX_H = 16'h3017;
  localparam logic [15:0] ADDR_MAX_L = 16'h3018;
  localparam logic [15:0] ADDR_MIN_H = 16'h3019;
  localparam logic [15:0] ADDR_MIN_L = 16'h301A;
  localparam logic [15:0] ADDR_OUT_CFG = 16'h301B;
  // Reset values.
  localparam logic [7:0] RST_SYS_PRE = 8'h05;
  localparam logic [7:0] RST_SYS_MULT = 8'h63;
  localparam logic [7:0] RST_SYS_POST = 8'h03;
  localparam logic [7:0] RST_SYS_CFG = 8'h01;
  localparam logic [7:0] RST_OUT_PRE = 8'h06;
  localparam logic [7:0] RST_OUT_DIV1 = 8'h7B;
  localparam logic [7:0] RST_OUT_DIV2 = 8'h00;
  localparam logic [7:0] RST_OUT_POST = 8'h07;
  localparam logic [7:0] RST_OUT_CTLA = 8'h01;
  localparam logic [7:0] RST_OUT_CTLB = 8'h00;
  localparam logic [7:0] RST_FRAC = 8'h00;
  localparam logic [7:0] RST_OUT_CFG = 8'h01;
  // Field positions of control register A.
  localparam int CTLA_LINK_HALF = 1;
  localparam int CTLA_ENABLE = 0;
  // Field positions of control register B.
  localparam int CTLB_STEP_HI = 6;
  localparam int CTLB_STEP_LO = 5;
  localparam int CTLB_FREQ_HI = 4;
  localparam int CTLB_FREQ_LO = 2;
  localparam int CTLB_SPREAD = 1;
  localparam int CTLB_FRAC = 0;
  // Field positions of the loop configuration registers.
  localparam int CFG_PREC_HI = 7;
  localparam int CFG_PREC_LO = 6;
  localparam int CFG_CNT_HI = 5;
  localparam int CFG_CNT_LO = 4;
  localparam int CFG_FAST_DIS = 3;
  localparam int CFG_CP_HI = 2;
  localparam int CFG_CP_LO = 0;
  // Constant term of the effective multiplication.
  localparam logic [21:0] MULT_OFFSET = 22'h00_0007;
  // Base period of the modulation counter in mclk cycles, scaled by 2**freq.
  localparam logic [11:0] MOD_BASE_CYCLES = 12'h010;
  // Modulator sweep states.
  typedef enum logic [2:0] {
    DPCC_IDLE = 3'b001,
    DPCC_UP = 3'b010,
    DPCC_DOWN = 3'b100
  } dpcc_sweep_t;
endpackage : dpcc_pkg

// ---- testbench/dpcc_ref_osc.sv ----
// Purpose: Free-running reference oscillator feeding the reference pin.
// Assumes: The oscillator is never gated.
// Notes: The period is a plain default and is unrelated in phase to mclk.
`timescale 1ns/1ps
module dpcc_ref_osc #(
  parameter int HALF_PS = 27300 // Half period in picoseconds.
) (
  output logic ref_clk // Reference clock to the pin.
);
  // The clock starts low and then toggles for the whole run.
  initial begin
    ref_clk = 1'b0;
    forever #(HALF_PS * 1ps) ref_clk = ~ref_clk;
  end
endmodule : dpcc_ref_osc

// ---- testbench/dpcc_top_assertions.sv ----
// Purpose: Concurrent checks on the ports of the clock configuration block.
// Assumes: One clock domain, mclk, with reset rst.
// Notes: Bound to every instance of dpcc_top.
`timescale 1ns/1ps
module dpcc_top_checker (
  input wire logic mclk, // Clock.
  input wire logic rst, // Reset.
  input wire logic ext_ref_clock_in, // Pin.
  input wire logic [15:0] reg_addr, // Address.
  input wire logic reg_wr, // Write.
  input wire logic [7:0] reg_wdata, // Data.
  input wire logic reg_rd, // Read.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic sys_ref_clk, // System ref.
  input wire logic out_ref_clk, // Output ref.
  input wire logic [4:0] sys_postdivider, // Post.
  input wire logic sys_fastlock_en, // Fast lock.
  input wire logic [8:0] out_first_divider, // First.
  input wire logic [7:0] out_second_divider, // Second.
  input wire logic output_clock_synth_en, // Enable.
  input wire logic link_half_rate, // Halving.
  input wire logic frac_mode_en, // Fractional.
  input wire logic spread_modulation_mode, // Spread.
  input wire logic [2:0] charge_pump_current, // Pump.
  input wire logic [9:0] frac_applied, // Fraction.
  input wire logic [21:0] mult_integer // Sum.
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // The applied fraction sweeps only while all three enables stand.
  wire logic sweep_on = spread_modulation_mode && output_clock_synth_en && frac_mode_en;
  // A write strobe aimed at one register.
  sequence s_wr(logic [15:0] a);
    reg_wr && reg_addr == a;
  endsequence
  a_ref_fanout: assert property (sys_ref_clk == ext_ref_clock_in &&
    out_ref_clk == ext_ref_clock_in) else $error("reference fanout differs");
  a_sys_post: assert property (s_wr(dpcc_pkg::ADDR_SYS_POST) |=>
    sys_postdivider == 5'h01 + {1'b0, $past(reg_wdata[3:0])}) else $error("system post wrong");
  a_div1_wrap: assert property (s_wr(dpcc_pkg::ADDR_OUT_DIV1) |=>
    out_first_divider == (($past(reg_wdata) == 8'h00) ? 9'h100 : {1'b0, $past(reg_wdata)}))
    else $error("first divider wrong");
  a_ctla_bits: assert property (s_wr(dpcc_pkg::ADDR_OUT_CTLA) |=>
    {link_half_rate, output_clock_synth_en} == $past(reg_wdata[1:0])) else $error("ctl A wrong");
  a_ctlb_modes: assert property (s_wr(dpcc_pkg::ADDR_OUT_CTLB) |=>
    {spread_modulation_mode, frac_mode_en} == $past(reg_wdata[1:0])) else $error("ctl B wrong");
  a_pump_cfg: assert property (s_wr(dpcc_pkg::ADDR_OUT_CFG) |=>
    charge_pump_current == $past(reg_wdata[2:0])) else $error("pump current wrong");
  a_fastlock_pol: assert property (s_wr(dpcc_pkg::ADDR_SYS_CFG) |=>
    sys_fastlock_en == !$past(reg_wdata[3])) else $error("fast lock polarity wrong");
  a_mult_sum: assert property (mult_integer == {13'h0000, out_first_divider[7:0], 1'b0} +
    dpcc_pkg::MULT_OFFSET + {14'h0000, out_second_divider}) else $error("multiplication wrong");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_read_ctla: assert property (reg_rd && !reg_wr && reg_addr == dpcc_pkg::ADDR_OUT_CTLA |=>
    reg_rdata == {6'h00, $past(link_half_rate), $past(output_clock_synth_en)})
    else $error("ctl A read wrong");
  a_frac_idle: assert property (!frac_mode_en [*2] |-> frac_applied == 10'h000)
    else $error("fraction not zero");
  a_step_gap: assert property (sweep_on && $changed(frac_applied) |=>
    $stable(frac_applied) [*8]) else $error("sweep stepped too soon");
endmodule : dpcc_top_checker
bind dpcc_top dpcc_top_checker dpcc_top_checker_i (.mclk, .rst, .ext_ref_clock_in, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .sys_ref_clk, .out_ref_clk, .sys_postdivider,
  .sys_fastlock_en, .out_first_divider, .out_second_divider, .output_clock_synth_en,
  .link_half_rate, .frac_mode_en, .spread_modulation_mode, .charge_pump_current,
  .frac_applied, .mult_integer);

// ---- testbench/dpcc_top_tb_top.sv ----
// Purpose: Self-checking bench for the clock configuration block.
// Assumes: The host writes only while the sensor stands in standby.
// Notes: Random bytes come from a fixed-seed shift register.
`timescale 1ns/1ps
module dpcc_top_tb_top;
  logic mclk = 1'b0; // Clock.
  logic rst = 1'b1; // Reset.
  logic ext_ref_clock_in; // Reference pin.
  logic [15:0] reg_addr = 16'h0000; // Address.
  logic reg_wr = 1'b0; // Write strobe.
  logic [7:0] reg_wdata = 8'h00; // Write data.
  logic reg_rd = 1'b0; // Read strobe.
  logic [7:0] reg_rdata, sys_predivider, sys_multiplier, reference_predivider; // Bytes.
  logic [7:0] out_second_divider; // Second divider.
  logic [4:0] sys_postdivider, out_postdivider; // Postdividers.
  logic [1:0] sys_lock_precision, sys_lock_count, out_lock_precision, out_lock_count; // Lock.
  logic [2:0] sys_charge_pump_current, charge_pump_current; // Pumps.
  logic sys_ref_clk, out_ref_clk, sys_fastlock_en, out_fastlock_en; // Single bits.
  logic output_clock_synth_en, link_half_rate, frac_mode_en, spread_modulation_mode; // Modes.
  logic [8:0] out_first_divider; // First divider.
  logic [9:0] frac_applied; // Fraction.
  logic [21:0] mult_integer; // Sum.
  logic [31:0] seed = 32'h5DFAADB2; // Random state.
  logic [7:0] sh [15]; // Shadow of every register.
  logic [7:0] rst_tab [15] = '{8'h05, 8'h63, 8'h03, 8'h01, 8'h06, 8'h7B, 8'h00, 8'h07, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01}; // Reset values.
  int mismatches = 0; // Mismatch count.
  int total_checks = 0; // Comparison count.
  dpcc_ref_osc dpcc_ref_osc_i (.ref_clk(ext_ref_clock_in));
  dpcc_top dpcc_top_i (.*);
  // The clock toggles every half period of 20 ns.
  always #20 mclk = ~mclk;
  // Next state of the random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Address of table entry i.
  function automatic logic [15:0] addr(input int i);
    return (i < 10) ? 16'h3000 + 16'(i) : 16'h300D + 16'(i);
  endfunction : addr
  // Bits that read back; unused bits read zero.
  function automatic logic [7:0] rmask(input int i);
    case (i)
      8, 10, 12: return 8'h03;
      9: return 8'h7F;
      default: return 8'hFF;
    endcase
  endfunction : rmask
  // Integer part of the multiplication from the two divider bytes.
  function automatic logic [21:0] exp_mult(input logic [7:0] d1, input logic [7:0] d2);
    return {13'h0000, d1, 1'b0} + 22'h000007 + {14'h0000, d2};
  endfunction : exp_mult
  // Compares one value and reports a difference.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  // One write cycle; the strobe stands over one rising edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  // One read cycle; the data is taken one cycle after the strobe.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // Cuts a hang short.
  initial begin
    #400us;
    mismatches++;
    test_done();
  end
  // Main sequence.
  initial begin
    logic [7:0] d;
    logic [7:0] w;
    logic [9:0] prev;
    int steps;
    logic hi_seen;
    logic lo_seen;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    sh = rst_tab;
    // Every register reads its reset value, unused bits as zero.
    for (int i = 0; i < 15; i++) begin
      rd(addr(i), d);
      check("reset value", d, rst_tab[i]);
    end
    check("mult reset", mult_integer, 22'h0000FD);
    // Random bytes everywhere; the spread bit stays clear so the sweep stays off.
    for (int r = 0; r < 45; r++) begin
      seed = lfsr(seed);
      w = (r % 15 == 9) ? (seed[7:0] & 8'hFD) : seed[7:0];
      wr(addr(r % 15), w);
      sh[r % 15] = w;
      rd(addr(r % 15), d);
      check("readback", d, w & rmask(r % 15));
      check("mult", mult_integer, exp_mult(sh[5], sh[6]));
    end
    // The predivider, multiplier, second divider and loop config outputs follow their shadow bytes.
    check("sys bytes", {sys_predivider, sys_multiplier}, {sh[0], sh[1]});
    check("sys cfg", {sys_lock_precision, sys_lock_count, !sys_fastlock_en}, sh[3][7:3]);
    check("sys pump", sys_charge_pump_current, sh[3][2:0]);
    check("out cfg", {out_lock_precision, out_lock_count, !out_fastlock_en}, sh[14][7:3]);
    check("out pump", charge_pump_current, sh[14][2:0]);
    check("out pre", reference_predivider, sh[4]);
    check("second div", out_second_divider, sh[6]);
    // Zero and top codes select the extreme divider values.
    wr(16'h3005, 8'h00);
    wr(16'h3007, 8'h0F);
    wr(16'h3002, 8'h00);
    check("first div", out_first_divider, 9'h100);
    check("out post", out_postdivider, 5'h10);
    check("sys post", sys_postdivider, 5'h01);
    // An unmapped place reads zero even after a write to it.
    wr(16'h3010, 8'hA5);
    rd(16'h3010, d);
    check("unmapped", d, 8'h00);
    // Write and read in one cycle: the read returns the old control bits.
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    reg_addr = 16'h3008;
    reg_wdata = 8'h02;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    check("old ctl A", reg_rdata, sh[8] & 8'h03);
    check("new ctl A", {link_half_rate, output_clock_synth_en}, 2'b10);
    // Limits 0x0F8 and 0x108, two codes a step, base counter rate.
    wr(16'h3017, 8'h01);
    wr(16'h3018, 8'h08);
    wr(16'h3019, 8'h00);
    wr(16'h301A, 8'hF8);
    wr(16'h3008, 8'h01);
    wr(16'h3009, 8'h21);
    check("frac at max", frac_applied, 10'h108);
    wr(16'h3009, 8'h23);
    repeat (3) @(negedge mclk);
    check("frac at min", frac_applied, 10'h0F8);
    prev = frac_applied;
    steps = 0;
    hi_seen = 1'b0;
    lo_seen = 1'b0;
    // Every change is one step of two codes and stays within the limits.
    for (int c = 0; c < 600; c++) begin
      @(negedge mclk);
      if (frac_applied !== prev) begin
        steps++;
        check("step", (frac_applied - prev == 10'h002) || (prev - frac_applied == 10'h002), 1);
        check("range", frac_applied >= 10'h0F8 && frac_applied <= 10'h108, 1);
        hi_seen |= (frac_applied == 10'h108);
        lo_seen |= hi_seen && (frac_applied == 10'h0F8);
      end
      prev = frac_applied;
    end
    check("turns", {hi_seen, lo_seen}, 2'b11);
    check("step rate", steps inside {[36:38]}, 1);
    // Fractional mode off clears the applied fraction.
    wr(16'h3009, 8'h00);
    repeat (2) @(negedge mclk);
    check("frac off", frac_applied, 10'h000);
    test_done();
  end
endmodule : dpcc_top_tb_top
